// ### pkg/svf_params.svh
`ifndef SVF_PARAMS_SVH
`define SVF_PARAMS_SVH
// ----------------------------------------
// link layout
// ----------------------------------------
`define SVF_LINK_WORDS 16
`define SVF_LINK_AW 4
`define SVF_SPD_WORDS 2
`define SVF_TRQ_WORDS 2
`define SVF_OFS_TRQ_LSB 8
// ----------------------------------------
// torque values, 0.1 % of rated torque, and highest torque selection code
// ----------------------------------------
`define SVF_FF_MIN 16'hD8F0
`define SVF_TRQ_MAX 16'h2710
`define SVF_FF_ZERO 16'h0000
`define SVF_SEL_MAX 3'h4
// ----------------------------------------
// host register map
// ----------------------------------------
`define SVF_REG_CTRL 8'h00
`define SVF_REG_SPEED 8'h04
`define SVF_REG_TRQ 8'h08
`define SVF_REG_OFS 8'h0C
`define SVF_REG_STAT 8'h10
`define SVF_CTL_FEED 0
`define SVF_CTL_STOP 1
`define SVF_CTL_DFWD 2
`define SVF_CTL_DREV 3
`define SVF_CTL_LINK 4
`define SVF_CTL_SERVO 5
`define SVF_LINK_PERIOD 20
`endif

// ### pkg/svf_pkg.sv
package svf_pkg;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SVF_TSEL_NONE,
        SVF_TSEL_FF_LIM,
        SVF_TSEL_FF,
        SVF_TSEL_LIM,
        SVF_TSEL_FWD_REV
    } svf_tsel_e;
    typedef enum {SVF_IDLE, SVF_RUN} svf_state_e;
    typedef logic [15:0] svf_word_t;
endpackage : svf_pkg

// ### pkg/svf_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "svf_params.svh"
interface svf_if;
    logic feed_cmd;
    logic stop_req;
    logic dir_fwd_lim;
    logic dir_rev_lim;
    logic link_we;
    logic [`SVF_LINK_AW-1:0] link_addr;
    logic [15:0] link_data;
    logic ack;
    logic busy;
    logic map_err;
    logic refused;
    modport dev (
        input feed_cmd, stop_req, dir_fwd_lim, dir_rev_lim, link_we, link_addr, link_data,
        output ack, busy, map_err, refused
    );
    modport host (
        output feed_cmd, stop_req, dir_fwd_lim, dir_rev_lim, link_we, link_addr, link_data,
        input ack, busy, map_err, refused
    );
endinterface : svf_if
`default_nettype wire

// ### design/svf_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module svf_clamp #(
    parameter int W = 16
) (
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] limit,
    output logic [W-1:0] result
);
    // ----------------------------------------
    // unsigned ceiling
    // ----------------------------------------
    wire over = value > limit;
    assign result = over ? limit : value;
endmodule : svf_clamp
`default_nettype wire

// ### design/svf_unit.sv
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "svf_params.svh"
module svf_unit #(
    parameter int WORDS = `SVF_LINK_WORDS,
    parameter int AW = `SVF_LINK_AW
) (
    input wire logic clk,
    input wire logic rst_n,
    svf_if.dev link,
    input wire logic ctrl_tick,
    input wire logic other_busy,
    input wire logic map_speed_ok,
    input wire logic map_torque_ok,
    input wire logic override_en,
    input wire logic man_fwd_lim,
    input wire logic man_rev_lim,
    input wire logic func_sel,
    input wire logic [AW-1:0] spd_ofs,
    input wire logic [2:0] trq_sel,
    input wire logic [AW-1:0] trq_ofs,
    input wire logic [31:0] max_speed,
    input wire logic [15:0] max_torque,
    input wire logic [31:0] fb_pos,
    output logic [31:0] cmd_pos,
    output logic drv_valid,
    output logic [31:0] drv_speed,
    output logic [15:0] drv_ff,
    output logic [15:0] drv_fwd_lim,
    output logic [15:0] drv_rev_lim,
    output logic drv_fwd_lim_on,
    output logic drv_rev_lim_on,
    output logic drv_qstop,
    output logic drv_master_tgt
);
    import svf_pkg::*;
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic ofs_ok(input logic [AW-1:0] ofs);
        ofs_ok = {1'b0, ofs} <= (AW+1)'(WORDS - `SVF_SPD_WORDS);
    endfunction : ofs_ok
    function automatic logic [AW-1:0] nxt_word(input logic [AW-1:0] ofs);
        nxt_word = ofs + AW'(1);
    endfunction : nxt_word
    function automatic logic [15:0] cap_ff(input logic [15:0] v, input logic [15:0] mx);
        logic signed [16:0] sv;
        sv = {v[15], v};
        if (sv > $signed({1'b0, mx})) begin
            cap_ff = mx;
        end else if (sv < -$signed({1'b0, mx})) begin
            cap_ff = 16'(-$signed({1'b0, mx}));
        end else begin
            cap_ff = v;
        end
    endfunction : cap_ff
    // ----------------------------------------
    // link area, latest words kept
    // ----------------------------------------
    svf_word_t mem_ff [WORDS];
    always_ff @(posedge clk) begin
        if (link.link_we) begin
            mem_ff[link.link_addr] <= link.link_data;
        end
    end
    // ----------------------------------------
    // start decode
    // ----------------------------------------
    svf_state_e state_ff;
    logic feed_d_ff;
    logic [AW-1:0] spd_ofs_ff;
    logic [AW-1:0] trq_ofs_ff;
    svf_tsel_e tsel_ff;
    logic master_ff;
    wire feed_rise = link.feed_cmd & ~feed_d_ff;
    wire sel_legal = trq_sel <= `SVF_SEL_MAX;
    wire trq_used = trq_sel != 3'(SVF_TSEL_NONE);
    wire map_bad = ~map_speed_ok | ~ofs_ok(spd_ofs) | ~sel_legal
        | (trq_used & (~map_torque_ok | ~ofs_ok(trq_ofs)));
    wire start_ok = feed_rise & ~other_busy & ~map_bad;
    wire running = state_ff == SVF_RUN;
    wire run_end = running & (~link.feed_cmd | link.stop_req);
    // ----------------------------------------
    // option word mapping
    // ----------------------------------------
    wire [15:0] opt1 = mem_ff[trq_ofs_ff];
    wire [15:0] opt2 = mem_ff[nxt_word(trq_ofs_ff)];
    wire ff_on = (tsel_ff == SVF_TSEL_FF_LIM) | (tsel_ff == SVF_TSEL_FF);
    wire bi_on = (tsel_ff == SVF_TSEL_FF_LIM) | (tsel_ff == SVF_TSEL_LIM);
    wire fr_on = tsel_ff == SVF_TSEL_FWD_REV;
    wire lim_on = bi_on | fr_on;
    wire [15:0] fwd_raw = fr_on ? opt1 : (bi_on ? opt2 : max_torque);
    wire [15:0] rev_raw = (fr_on | bi_on) ? opt2 : max_torque;
    wire [15:0] ff_raw = ff_on ? opt1 : `SVF_FF_ZERO;
    wire [15:0] ff_capped = cap_ff(ff_raw, max_torque);
    wire [15:0] fwd_capped;
    wire [15:0] rev_capped;
    svf_clamp #(.W(16)) u_fwd (
        .value(fwd_raw),
        .limit(max_torque),
        .result(fwd_capped)
    );
    svf_clamp #(.W(16)) u_rev (
        .value(rev_raw),
        .limit(max_torque),
        .result(rev_capped)
    );
    // ----------------------------------------
    // speed path, no override scaling
    // ----------------------------------------
    wire [31:0] spd_raw = {mem_ff[nxt_word(spd_ofs_ff)], mem_ff[spd_ofs_ff]};
    wire [31:0] spd_capped;
    wire unused_ovr = override_en;
    svf_clamp #(.W(32)) u_spd (
        .value(spd_raw),
        .limit(max_speed),
        .result(spd_capped)
    );
    // ----------------------------------------
    // limit bit priority
    // ----------------------------------------
    wire nxt_fwd_on = (running & lim_on) ? link.dir_fwd_lim : man_fwd_lim;
    wire nxt_rev_on = (running & lim_on) ? link.dir_rev_lim : man_rev_lim;
    // ----------------------------------------
    // state and selection latch
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SVF_IDLE;
            feed_d_ff <= 1'b0;
            spd_ofs_ff <= '0;
            trq_ofs_ff <= '0;
            tsel_ff <= SVF_TSEL_NONE;
            master_ff <= 1'b0;
        end else begin
            feed_d_ff <= link.feed_cmd;
            unique case (state_ff)
                SVF_IDLE: begin
                    if (start_ok) begin
                        state_ff <= SVF_RUN;
                        spd_ofs_ff <= spd_ofs;
                        trq_ofs_ff <= trq_ofs;
                        tsel_ff <= svf_tsel_e'(trq_sel);
                        master_ff <= func_sel;
                    end
                end
                SVF_RUN: begin
                    if (run_end) begin
                        state_ff <= SVF_IDLE;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // status flags
    // ----------------------------------------
    logic ack_ff;
    logic err_ff;
    logic ref_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            ref_ff <= 1'b0;
        end else begin
            ack_ff <= (ack_ff | start_ok) & ~run_end;
            err_ff <= link.feed_cmd & (err_ff | (feed_rise & ~other_busy & map_bad));
            ref_ff <= link.feed_cmd & (ref_ff | (feed_rise & other_busy));
        end
    end
    assign link.ack = ack_ff;
    assign link.busy = running;
    assign link.map_err = err_ff;
    assign link.refused = ref_ff;
    // ----------------------------------------
    // drive outputs
    // ----------------------------------------
    logic valid_ff;
    logic qstop_ff;
    logic [31:0] spd_ff;
    logic [15:0] ff_ff;
    logic [15:0] fwd_ff;
    logic [15:0] rev_ff;
    logic fwd_on_ff;
    logic rev_on_ff;
    logic [31:0] pos_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            qstop_ff <= 1'b0;
            spd_ff <= '0;
            ff_ff <= `SVF_FF_ZERO;
            fwd_ff <= `SVF_TRQ_MAX;
            rev_ff <= `SVF_TRQ_MAX;
            fwd_on_ff <= 1'b0;
            rev_on_ff <= 1'b0;
            pos_ff <= '0;
        end else begin
            valid_ff <= running & ~run_end & ctrl_tick;
            qstop_ff <= running & link.stop_req;
            fwd_on_ff <= nxt_fwd_on;
            rev_on_ff <= nxt_rev_on;
            if (running) begin
                pos_ff <= fb_pos;
            end
            if (run_end | ~running) begin
                spd_ff <= '0;
                ff_ff <= `SVF_FF_ZERO;
                fwd_ff <= max_torque;
                rev_ff <= max_torque;
            end else if (ctrl_tick) begin
                spd_ff <= spd_capped;
                ff_ff <= ff_capped;
                fwd_ff <= fwd_capped;
                rev_ff <= rev_capped;
            end
        end
    end
    assign cmd_pos = running ? fb_pos : pos_ff;
    assign drv_valid = valid_ff;
    assign drv_speed = spd_ff;
    assign drv_ff = ff_ff;
    assign drv_fwd_lim = fwd_ff;
    assign drv_rev_lim = rev_ff;
    assign drv_fwd_lim_on = fwd_on_ff;
    assign drv_rev_lim_on = rev_on_ff;
    assign drv_qstop = qstop_ff;
    assign drv_master_tgt = master_ff & ~unused_ovr | master_ff;
endmodule : svf_unit
`default_nettype wire

// ### design/svf_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "svf_params.svh"
module svf_host #(
    parameter int AW = `SVF_LINK_AW,
    parameter int PERIOD = `SVF_LINK_PERIOD
) (
    input wire logic clk,
    input wire logic rst_n,
    svf_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import svf_pkg::*;
    // ----------------------------------------
    // bus address phase
    // ----------------------------------------
    logic wr_ff;
    logic [7:0] addr_ff;
    wire take = hsel & hready & htrans[1];
    wire unused_size = |hsize;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= 1'b0;
            addr_ff <= '0;
        end else begin
            wr_ff <= take & hwrite;
            addr_ff <= take ? haddr[7:0] : addr_ff;
        end
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0] ctrl_ff;
    logic stop_ff;
    logic [31:0] speed_ff;
    logic [31:0] trq_ff;
    logic [15:0] ofs_ff;
    wire wr_ctrl = wr_ff & (addr_ff == `SVF_REG_CTRL);
    wire ready_for_feed = ctrl_ff[`SVF_CTL_LINK] & ctrl_ff[`SVF_CTL_SERVO];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= '0;
            stop_ff <= 1'b0;
            speed_ff <= '0;
            trq_ff <= '0;
            ofs_ff <= '0;
        end else begin
            stop_ff <= wr_ctrl & hwdata[`SVF_CTL_STOP];
            if (wr_ctrl) begin
                ctrl_ff <= hwdata[5:0];
            end
            if (wr_ff & (addr_ff == `SVF_REG_SPEED)) begin
                speed_ff <= hwdata;
            end
            if (wr_ff & (addr_ff == `SVF_REG_TRQ)) begin
                trq_ff <= hwdata;
            end
            if (wr_ff & (addr_ff == `SVF_REG_OFS)) begin
                ofs_ff <= hwdata[15:0];
            end
        end
    end
    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [31:0] stat_word = {28'h0000000, link.refused, link.map_err, link.busy, link.ack};
    wire [31:0] rd_mux =
        (addr_ff == `SVF_REG_CTRL) ? {26'h0, ctrl_ff} :
        (addr_ff == `SVF_REG_SPEED) ? speed_ff :
        (addr_ff == `SVF_REG_TRQ) ? trq_ff :
        (addr_ff == `SVF_REG_OFS) ? {16'h0000, ofs_ff} :
        (addr_ff == `SVF_REG_STAT) ? stat_word : 32'h00000000;
    assign hrdata = rd_mux;
    assign hreadyout = 1'b1;
    assign hresp = unused_size & 1'b0;
    // ----------------------------------------
    // link refresh, four words per period
    // ----------------------------------------
    logic [15:0] tick_ff;
    logic we_ff;
    logic [AW-1:0] waddr_ff;
    logic [15:0] wdata_ff;
    wire period_end = tick_ff == 16'(PERIOD - 1);
    wire [AW-1:0] spd_base = ofs_ff[AW-1:0];
    wire [AW-1:0] trq_base = ofs_ff[`SVF_OFS_TRQ_LSB+AW-1:`SVF_OFS_TRQ_LSB];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= '0;
            we_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
        end else begin
            tick_ff <= (period_end | ~ctrl_ff[`SVF_CTL_LINK]) ? 16'h0000 : tick_ff + 16'h0001;
            we_ff <= 1'b0;
            if (ctrl_ff[`SVF_CTL_LINK] & (tick_ff < 16'(`SVF_SPD_WORDS + `SVF_TRQ_WORDS))) begin
                we_ff <= 1'b1;
                unique case (tick_ff[1:0])
                    2'h0: begin
                        waddr_ff <= spd_base;
                        wdata_ff <= speed_ff[15:0];
                    end
                    2'h1: begin
                        waddr_ff <= spd_base + AW'(1);
                        wdata_ff <= speed_ff[31:16];
                    end
                    2'h2: begin
                        waddr_ff <= trq_base;
                        wdata_ff <= trq_ff[15:0];
                    end
                    2'h3: begin
                        waddr_ff <= trq_base + AW'(1);
                        wdata_ff <= trq_ff[31:16];
                    end
                endcase
            end
        end
    end
    assign link.link_we = we_ff;
    assign link.link_addr = waddr_ff;
    assign link.link_data = wdata_ff;
    assign link.feed_cmd = ctrl_ff[`SVF_CTL_FEED] & ready_for_feed;
    assign link.stop_req = stop_ff;
    assign link.dir_fwd_lim = ctrl_ff[`SVF_CTL_DFWD];
    assign link.dir_rev_lim = ctrl_ff[`SVF_CTL_DREV];
endmodule : svf_host
`default_nettype wire

// ### tb/svf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module svf_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic feed_cmd,
    input wire logic stop_req,
    input wire logic link_we,
    input wire logic [3:0] link_addr,
    input wire logic ack,
    input wire logic busy,
    input wire logic map_err,
    input wire logic refused
);
    // ----------------------------------------
    // handshake and link checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_ack_busy: assert property (ack |-> busy)
        else $error("ack high while idle");
    chk_start_edge: assert property ($rose(busy) |-> $past(feed_cmd) && !$past(feed_cmd, 2) && ack)
        else $error("busy rose without a flag edge");
    chk_start_answer: assert property ($rose(feed_cmd) && !busy |=> busy || refused || map_err)
        else $error("start edge left unanswered");
    chk_feed_off: assert property (busy && !feed_cmd |=> !busy && !ack)
        else $error("run kept after flag off");
    chk_stop_now: assert property (busy && stop_req |=> !busy)
        else $error("stop request not immediate");
    chk_refuse_idle: assert property (refused |-> !busy && !ack)
        else $error("refused start still running");
    chk_map_idle: assert property (map_err |-> !busy)
        else $error("mapping error while running");
    chk_fault_hold: assert property (refused && feed_cmd |=> refused)
        else $error("refusal dropped with flag high");
    chk_fault_clear: assert property (!feed_cmd && (refused || map_err) |=> !refused && !map_err)
        else $error("fault flag kept after flag off");
    chk_burst_len: assert property ($rose(link_we) |-> link_we [*4] ##1 !link_we)
        else $error("link burst not four words");
    chk_burst_pair: assert property ($rose(link_we) |=> link_addr == $past(link_addr) + 4'h1)
        else $error("speed words not adjacent");
endmodule : svf_assertions
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // stimulus and wiring
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic ctrl_tick = 1'b0;
    logic other_busy = 1'b0;
    logic map_speed_ok = 1'b1;
    logic map_torque_ok = 1'b1;
    logic override_en = 1'b0;
    logic man_fwd_lim = 1'b0;
    logic man_rev_lim = 1'b0;
    logic func_sel = 1'b0;
    logic [3:0] spd_ofs = 4'h0;
    logic [3:0] trq_ofs = 4'h0;
    logic [2:0] trq_sel = 3'h0;
    logic [2:0] tcnt = 3'h0;
    logic [31:0] max_speed = 32'hFFFF;
    logic [15:0] max_torque = 16'h2710;
    logic [31:0] fb_pos = 32'h0;
    logic [31:0] cmd_pos, drv_speed;
    logic [15:0] drv_ff, drv_fwd_lim, drv_rev_lim;
    logic drv_valid, drv_fwd_lim_on, drv_rev_lim_on, drv_qstop, drv_master_tgt;
    int bad_count = 0;
    int samples_checked = 0;
    int qcount = 0;

    always #25 clk = ~clk;
    always @(posedge clk) begin
        tcnt <= tcnt + 3'h1;
        ctrl_tick <= (tcnt == 3'h7);
        fb_pos <= fb_pos + 32'h3;
    end
    always @(negedge clk) if (drv_qstop === 1'b1) qcount++;

    svf_if link_if();
    svf_host #(.PERIOD(8)) svf_host_i (.clk(clk), .rst_n(rst_n), .link(link_if), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata));
    svf_unit svf_unit_i (.clk(clk), .rst_n(rst_n), .link(link_if), .ctrl_tick(ctrl_tick),
        .other_busy(other_busy), .map_speed_ok(map_speed_ok), .map_torque_ok(map_torque_ok),
        .override_en(override_en), .man_fwd_lim(man_fwd_lim), .man_rev_lim(man_rev_lim),
        .func_sel(func_sel), .spd_ofs(spd_ofs), .trq_sel(trq_sel), .trq_ofs(trq_ofs),
        .max_speed(max_speed), .max_torque(max_torque), .fb_pos(fb_pos), .cmd_pos(cmd_pos),
        .drv_valid(drv_valid), .drv_speed(drv_speed), .drv_ff(drv_ff),
        .drv_fwd_lim(drv_fwd_lim), .drv_rev_lim(drv_rev_lim), .drv_fwd_lim_on(drv_fwd_lim_on),
        .drv_rev_lim_on(drv_rev_lim_on), .drv_qstop(drv_qstop), .drv_master_tgt(drv_master_tgt));
    svf_assertions svf_assertions_i (.clk(clk), .rst_n(rst_n), .feed_cmd(link_if.feed_cmd),
        .stop_req(link_if.stop_req), .link_we(link_if.link_we), .link_addr(link_if.link_addr),
        .ack(link_if.ack), .busy(link_if.busy), .map_err(link_if.map_err),
        .refused(link_if.refused));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk

    task rdy(output logic [31:0] q);
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge clk);
            q = hrdata;
            r = hreadyout;
            @(posedge clk);
            n++;
            if (n > 50) begin
                bad_count++;
                wrap_up();
            end
        end
    endtask : rdy

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy(q);
        htrans <= 2'h0;
        hwdata <= d;
        rdy(q);
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(e, q);
    endtask : rd_chk

    task valid(input int k);
        int n;
        n = 0;
        repeat (k) begin
            do begin
                @(negedge clk);
                n++;
            end while (drv_valid !== 1'b1 && n < 200);
        end
        if (n >= 200) begin
            bad_count++;
            wrap_up();
        end
    endtask : valid

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task sc_reset;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h20, 32'h0);
        @(negedge clk);
        chk(32'h0, {16'h0, drv_ff});
        chk({16'h0, max_torque}, {16'h0, drv_fwd_lim});
    endtask : sc_reset

    task sc_clamp;
        wr(8'h0C, 32'h0602);
        spd_ofs <= 4'h2;
        trq_ofs <= 4'h6;
        trq_sel <= 3'h1;
        max_speed <= 32'h10000;
        max_torque <= 16'h1000;
        override_en <= 1'b1;
        func_sel <= 1'b1;
        wr(8'h04, 32'h20000);
        wr(8'h08, 32'h2000F000);
        wr(8'h00, 32'h30);
        wr(8'h00, 32'h35);
        valid(3);
        chk(max_speed, drv_speed);
        chk(32'hF000, {16'h0, drv_ff});
        chk(32'h1000, {16'h0, drv_fwd_lim});
        chk(fb_pos, cmd_pos);
        chk(32'h1, {31'h0, drv_master_tgt});
        rd_chk(8'h10, 32'h3);
        wr(8'h04, 32'h1234);
        wr(8'h08, 32'h08002000);
        valid(3);
        chk(32'h1234, drv_speed);
        chk(32'h1000, {16'h0, drv_ff});
        chk(32'h0800, {16'h0, drv_rev_lim});
        wr(8'h00, 32'h30);
        repeat (2) @(negedge clk);
        chk(32'h0, {16'h0, drv_ff});
        chk(32'h1000, {16'h0, drv_rev_lim});
        rd_chk(8'h10, 32'h0);
    endtask : sc_clamp

    task sc_modes;
        logic [15:0] ef, efw, erv;
        logic lim;
        wr(8'h08, 32'h02000100);
        max_torque <= 16'h2710;
        man_fwd_lim <= 1'b1;
        man_rev_lim <= 1'b0;
        for (int s = 0; s < 5; s++) begin
            trq_sel <= s[2:0];
            func_sel <= s[0];
            wr(8'h00, 32'h39);
            valid(3);
            lim = (s == 1 || s > 2);
            ef = (s == 1 || s == 2) ? 16'h0100 : 16'h0;
            efw = (s == 4) ? 16'h0100 : (lim ? 16'h0200 : 16'h2710);
            erv = lim ? 16'h0200 : 16'h2710;
            chk({16'h0, ef}, {16'h0, drv_ff});
            chk({16'h0, efw}, {16'h0, drv_fwd_lim});
            chk({16'h0, erv}, {16'h0, drv_rev_lim});
            chk({30'h0, !lim, lim}, {30'h0, drv_fwd_lim_on, drv_rev_lim_on});
            chk({31'h0, s[0]}, {31'h0, drv_master_tgt});
            if (s == 4) begin
                wr(8'h00, 32'h3B);
                repeat (3) @(negedge clk);
                chk(32'h1, qcount);
                rd_chk(8'h10, 32'h0);
            end
            wr(8'h00, 32'h30);
        end
    endtask : sc_modes

    task fault(input logic ob, ms, mt, input logic [3:0] so, input logic [2:0] ts,
               input logic [31:0] e);
        other_busy <= ob;
        map_speed_ok <= ms;
        map_torque_ok <= mt;
        spd_ofs <= so;
        trq_sel <= ts;
        wr(8'h00, 32'h31);
        rd_chk(8'h10, e);
        wr(8'h00, 32'h30);
        rd_chk(8'h10, 32'h0);
    endtask : fault

    task sc_faults;
        fault(1'b1, 1'b1, 1'b1, 4'h2, 3'h0, 32'h8);
        fault(1'b0, 1'b1, 1'b0, 4'h2, 3'h2, 32'h4);
        fault(1'b0, 1'b0, 1'b1, 4'h2, 3'h0, 32'h4);
        fault(1'b0, 1'b1, 1'b1, 4'hF, 3'h0, 32'h4);
        fault(1'b0, 1'b1, 1'b1, 4'h2, 3'h5, 32'h4);
        fault(1'b0, 1'b1, 1'b1, 4'h2, 3'h0, 32'h3);
    endtask : sc_faults

    task sc_midreset;
        wr(8'h00, 32'h31);
        valid(1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h00, 32'h0);
        chk({16'h0, max_torque}, {16'h0, drv_rev_lim});
        chk(32'h0, {16'h0, drv_ff});
    endtask : sc_midreset

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        sc_reset();
        sc_clamp();
        sc_modes();
        sc_faults();
        sc_midreset();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
